//--- bench/peripheral_pin_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ppc_defs.vh"
module peripheral_pin_control_tb_top;
   // ****************************************
   // Harness
   // ****************************************
   localparam int SLOT = 4;
   typedef struct {logic [7:0] d; logic on;} ppc_row_t;
   logic        mclk_in, nrst_in, tb_scl, tb_sda, thermal_compare_in;
   logic [1:0]  lamp_select_out;
   logic        host_notify_out, host_notify_oe_out, ramp_charge_out;
   logic        ctrl_i2c_clock_pin_out, ctrl_i2c_clock_pin_oe_out;
   logic        ctrl_i2c_data_pin_out, ctrl_i2c_data_pin_oe_out;
   logic        flash_serial_clock_out, flash_tx_out, flash_rx_in;
   logic        flash_select0_n_out, aux_select1_n_out;
   logic [39:0] cmd;
   logic [8:0]  rx;
   logic [7:0]  d;
   int          error_cnt = 0, n_compared = 0, rises = 0, i;
   ppc_row_t    rows [4] = '{'{8'h00, 0}, '{8'h01, 1}, '{8'hfe, 0},
                            '{8'hff, 1}};
   // Open drain with pull-ups
   wire ctrl_i2c_clock_pin_in = tb_scl
      & ~(ctrl_i2c_clock_pin_oe_out & ~ctrl_i2c_clock_pin_out);
   wire ctrl_i2c_data_pin_in = tb_sda
      & ~(ctrl_i2c_data_pin_oe_out & ~ctrl_i2c_data_pin_out);
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   always @(posedge ramp_charge_out) rises++;
   // Short slots keep the run small
   ppc_top #(.LAMP_SLOT(16'h0004), .SETTLE(8'h02)) uut (
      .mclk_in                   (mclk_in),
      .nrst_in                   (nrst_in),
      .lamp_select_out           (lamp_select_out),
      .host_notify_out           (host_notify_out),
      .host_notify_oe_out        (host_notify_oe_out),
      .ctrl_i2c_clock_pin_in     (ctrl_i2c_clock_pin_in),
      .ctrl_i2c_clock_pin_out    (ctrl_i2c_clock_pin_out),
      .ctrl_i2c_clock_pin_oe_out (ctrl_i2c_clock_pin_oe_out),
      .ctrl_i2c_data_pin_in      (ctrl_i2c_data_pin_in),
      .ctrl_i2c_data_pin_out     (ctrl_i2c_data_pin_out),
      .ctrl_i2c_data_pin_oe_out  (ctrl_i2c_data_pin_oe_out),
      .flash_serial_clock_out    (flash_serial_clock_out),
      .flash_tx_out              (flash_tx_out),
      .flash_rx_in               (flash_rx_in),
      .flash_select0_n_out       (flash_select0_n_out),
      .aux_select1_n_out         (aux_select1_n_out),
      .thermal_compare_in        (thermal_compare_in),
      .ramp_charge_out           (ramp_charge_out)
   );
   ppc_flash #(.BOOT_BYTE(8'h01)) flash (.sclk_in(flash_serial_clock_out),
      .cs_n_in(flash_select0_n_out), .mosi_in(flash_tx_out),
      .miso_out(flash_rx_in), .cmd_out(cmd));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Inputs move at least 6 cycles apart for the edge detect
   task automatic i2c_bit(logic b, output logic r);
      tb_sda <= b;
      tick(6);
      tb_scl <= 1'b1;
      tick(3);
      r = ctrl_i2c_data_pin_in;
      tick(3);
      tb_scl <= 1'b0;
      tick(6);
   endtask
   task automatic xfer(logic [8:0] tx);
      for (int k = 8; k >= 0; k--) i2c_bit(tx[k], rx[k]);
   endtask
   // 1 gives a start, 0 a stop
   task automatic cond(logic st);
      tb_sda <= st;
      tick(6);
      tb_scl <= 1'b1;
      tick(6);
      tb_sda <= ~st;
      tick(6);
      if (st) begin
         tb_scl <= 1'b0;
         tick(6);
      end
   endtask
   task automatic i2c_wr(logic [6:0] a, logic [7:0] v);
      cond(1'b1);
      xfer({a, 2'b01});
      chk("addr ack", rx[0], a != `PPC_I2C_ADDR);
      if (a == `PPC_I2C_ADDR) begin
         xfer({v, 1'b1});
         chk("data ack", rx[0], 0);
      end
      cond(1'b0);
   endtask
   task automatic i2c_rd;
      cond(1'b1);
      xfer({`PPC_I2C_ADDR, 2'b11});
      chk("read ack", rx[0], 0);
      xfer(9'h1ff);
      d = rx[8:1];
      cond(1'b0);
   endtask
   task automatic rst_chk;
      chk("reset outs", {lamp_select_out, host_notify_oe_out,
          flash_select0_n_out, aux_select1_n_out}, 5'h03);
   endtask
   task automatic wait_lamp(logic [1:0] v, logic same);
      for (i = 0; i < 50 && (lamp_select_out === v) != same; i++) tick(1);
      if (i == 50) begin
         error_cnt++;
         wrap_up;
      end
   endtask
   task automatic wait_boot;
      for (i = 0; i < 3000 && host_notify_out !== 1'b0; i++) tick(1);
      if (i == 3000) begin
         error_cnt++;
         wrap_up;
      end
      tick(2);
      chk("boot cmd", cmd, 40'h0300000000);
      chk("selects", {flash_select0_n_out, aux_select1_n_out}, 3);
      chk("lamp boot", |lamp_select_out, 1);
      chk("notify", {host_notify_out, host_notify_oe_out}, 1);
      chk("scl oe", ctrl_i2c_clock_pin_oe_out, 0);
      $display("boot test done");
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      nrst_in = 1'b1;
      tb_scl = 1'b1;
      tb_sda = 1'b1;
      thermal_compare_in = 1'b1;
      // A real falling edge, so the async reset cannot be missed
      #1 nrst_in = 1'b0;
      tick(4);
      rst_chk;
      nrst_in <= 1'b1;
      wait_boot;
      foreach (rows[r]) begin
         i2c_wr(`PPC_I2C_ADDR, rows[r].d);
         tick(2);
         chk("lamp run", |lamp_select_out, rows[r].on);
      end
      $display("control test done");
      wait_lamp(2'h3, 1'b1);
      wait_lamp(2'h3, 1'b0);
      for (i = 0; i < 3 * SLOT; i++) begin
         chk("lamp order", lamp_select_out, (i / SLOT) % 3 + 1);
         tick(1);
      end
      i2c_wr(7'h1c, 8'h00);
      tick(2);
      chk("lamp kept", |lamp_select_out, 1);
      $display("sequence test done");
      // Two full conversions fit in the wait
      for (int v = 1; v >= 0; v--) begin
         thermal_compare_in <= v[0];
         tick(9000);
         i2c_rd;
         chk("temp", d, v ? 8'hff : 8'h00);
      end
      chk("ramp ran", rises != 0, 1);
      $display("temperature test done");
      nrst_in <= 1'b0;
      tick(2);
      rst_chk;
      nrst_in <= 1'b1;
      wait_boot;
      wrap_up;
   end
endmodule
`default_nettype wire

//--- bench/ppc_flash.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Boot flash, mode 0, MSB first
// ****************************************
module ppc_flash #(
   parameter logic [7:0] BOOT_BYTE = 8'h01
) (
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        mosi_in,
   output var  logic        miso_out,
   output var  logic [39:0] cmd_out
);
   logic [5:0] n;
   initial miso_out = 1'b0;
   // First bit valid as soon as select falls
   always @(negedge cs_n_in) begin
      n = 6'h00;
      cmd_out = 40'h0;
      miso_out = 1'b0;
   end
   always @(posedge sclk_in) begin
      if (!cs_n_in) begin
         cmd_out = {cmd_out[38:0], mosi_in};
         n = n + 6'h01;
      end
   end
   // Toggle pattern under the command, boot byte last
   always @(negedge sclk_in) begin
      if (!cs_n_in) begin
         miso_out = (n < 6'h20) ? n[0] : BOOT_BYTE[~n[2:0]];
      end
   end
   // Released line must not look like held data
   always @(posedge cs_n_in) miso_out = ~miso_out;
endmodule
`default_nettype wire

//--- bench/ppc_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Pin checker
// ****************************************
module ppc_chk #(
   parameter [15:0] LAMP_SLOT = 16'h0004
) (
   input wire logic       mclk_in,
   input wire logic       nrst_in,
   input wire logic [1:0] lamp_select_out,
   input wire logic       host_notify_out,
   input wire logic       host_notify_oe_out,
   input wire logic       ctrl_i2c_clock_pin_in,
   input wire logic       ctrl_i2c_data_pin_out,
   input wire logic       ctrl_i2c_data_pin_oe_out,
   input wire logic       flash_serial_clock_out,
   input wire logic       flash_select0_n_out,
   input wire logic       aux_select1_n_out,
   input wire logic       ramp_charge_out
);
   logic [1:0]  prev;
   logic [15:0] held;
   logic        step;
   assign step = lamp_select_out != prev && prev != 2'h0
                 && lamp_select_out != 2'h0;
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         prev <= 2'h0;
         held <= 16'h0000;
      end else begin
         prev <= lamp_select_out;
         held <= (lamp_select_out != prev) ? 16'h0001 : held + 16'h0001;
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   chk_lamp_rst: assert property (disable iff (1'b0)
      !nrst_in |-> lamp_select_out == 2'h0 && !host_notify_oe_out)
      else $error("lamp or notify active in reset");
   chk_lamp_boot: assert property (
      host_notify_out && host_notify_oe_out |-> lamp_select_out == 2'h0)
      else $error("lamp on during boot");
   chk_notify_hold: assert property (
      host_notify_oe_out && !host_notify_out |=> !host_notify_out)
      else $error("notify rose after boot");
   chk_boot_end: assert property (
      $rose(flash_select0_n_out) == $fell(host_notify_out))
      else $error("boot end and notify fall apart");
   chk_sel_idle: assert property (
      aux_select1_n_out && (flash_select0_n_out || host_notify_out))
      else $error("select low outside boot");
   chk_sclk_idle: assert property (
      flash_select0_n_out |-> !flash_serial_clock_out)
      else $error("serial clock runs unselected");
   chk_lamp_order: assert property (
      step |-> lamp_select_out == ((prev == 2'h3) ? 2'h1 : prev + 2'h1))
      else $error("lamp colour out of order");
   chk_lamp_slot: assert property (
      step |-> held == LAMP_SLOT)
      else $error("lamp slot length wrong");
   chk_sda_ack: assert property (
      $rose(ctrl_i2c_data_pin_oe_out) |-> !ctrl_i2c_clock_pin_in)
      else $error("data driven while clock high");
   chk_sda_od: assert property (
      ctrl_i2c_data_pin_oe_out |-> !ctrl_i2c_data_pin_out)
      else $error("data pin driven high");
   chk_ramp_boot: assert property (
      host_notify_out |-> !ramp_charge_out)
      else $error("ramp runs during boot");
   cover property (lamp_select_out == 2'h3);
   cover property ($fell(host_notify_out));
   cover property ($rose(ctrl_i2c_data_pin_oe_out));
endmodule
bind ppc_top ppc_chk #(.LAMP_SLOT(LAMP_SLOT)) chk_i (
   .mclk_in                  (mclk_in),
   .nrst_in                  (nrst_in),
   .lamp_select_out          (lamp_select_out),
   .host_notify_out          (host_notify_out),
   .host_notify_oe_out       (host_notify_oe_out),
   .ctrl_i2c_clock_pin_in    (ctrl_i2c_clock_pin_in),
   .ctrl_i2c_data_pin_out    (ctrl_i2c_data_pin_out),
   .ctrl_i2c_data_pin_oe_out (ctrl_i2c_data_pin_oe_out),
   .flash_serial_clock_out   (flash_serial_clock_out),
   .flash_select0_n_out      (flash_select0_n_out),
   .aux_select1_n_out        (aux_select1_n_out),
   .ramp_charge_out          (ramp_charge_out)
);
`default_nettype wire

//--- pkg/ppc_defs.vh
`ifndef PPC_DEFS_VH
`define PPC_DEFS_VH

// ****************************************
// Lamp select codes
// ****************************************
`define PPC_LAMP_NONE      2'h0
`define PPC_LAMP_RED       2'h1
`define PPC_LAMP_GREEN     2'h2
`define PPC_LAMP_BLUE      2'h3

// ****************************************
// Boot read from flash, and lamp slot length
// ****************************************
`define PPC_FLASH_READ     8'h03
`define PPC_FLASH_FILL     8'h00
`define PPC_BOOT_LAST      3'h4
`define PPC_SPI_DIV        8'h04
`define PPC_LAMP_SLOT      16'h03e8

// ****************************************
// Control port
// ****************************************
`define PPC_I2C_ADDR       7'h1b
`define PPC_I2C_BITS       4'h8
`define PPC_CTRL_RUN       0
`define PPC_CTRL_RESET     8'h00

// ****************************************
// Temperature conversion
// ****************************************
`define PPC_SETTLE         8'h10

`endif

//--- src/ppc_spi.v
`timescale 1ns/1ns
`default_nettype none
`include "ppc_defs.vh"

// ****************************************
// Mode 0 byte shifter, MSB first
// ****************************************
module ppc_spi #(
   parameter [7:0] DIV = `PPC_SPI_DIV
) (
   input  wire       mclk_in,
   input  wire       nrst_in,
   input  wire       go_in,
   input  wire [7:0] tx_in,
   input  wire       miso_in,
   output reg        done_out,
   output reg  [7:0] rx_out,
   output reg        sclk_out,
   output reg        mosi_out
);

   reg        busy;
   reg [7:0]  div_cnt;
   reg [2:0]  bit_cnt;
   reg [7:0]  tx_sh;

   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy     <= 1'b0;
         div_cnt  <= 8'h00;
         bit_cnt  <= 3'h0;
         tx_sh    <= 8'h00;
         rx_out   <= 8'h00;
         sclk_out <= 1'b0;
         mosi_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (!busy) begin
            if (go_in) begin
               busy     <= 1'b1;
               mosi_out <= tx_in[7];
               tx_sh    <= {tx_in[6:0], 1'b0};
               bit_cnt  <= 3'h0;
               div_cnt  <= 8'h00;
            end
         end else if (div_cnt == DIV - 8'h01) begin
            div_cnt  <= 8'h00;
            sclk_out <= ~sclk_out;
            if (!sclk_out) begin
               rx_out <= {rx_out[6:0], miso_in};
            end else if (bit_cnt == 3'h7) begin
               busy     <= 1'b0;
               done_out <= 1'b1;
            end else begin
               bit_cnt  <= bit_cnt + 3'h1;
               mosi_out <= tx_sh[7];
               tx_sh    <= {tx_sh[6:0], 1'b0};
            end
         end else begin
            div_cnt <= div_cnt + 8'h01;
         end
      end
   end

endmodule

`default_nettype wire

//--- src/ppc_top.v
// What this block does
// - Lamp select shows 00 none, 01 red, 10 green, 11 blue from the sequence.
// - Lamp select is held at 00 while reset is asserted.
// - Lamp select stays 00 for the whole of boot after reset.
// - Host notify is high while boot runs and falls when boot completes.
// - Host notify is not driven during reset.
// - Port 0 is an I2C target used by the host as the control port.
// - The block is SPI master: it drives clock and data out, samples data in.
// - Two active-low selects: select 0 for flash, select 1 unused and high.
// - The comparator input is the compare result of a SAR conversion.
// - The ramp charge output drives the RC reference of the comparator.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_defs.vh"

module ppc_top #(
   parameter [6:0]  I2C_ADDR  = `PPC_I2C_ADDR,
   parameter [15:0] LAMP_SLOT = `PPC_LAMP_SLOT,
   parameter [7:0]  SETTLE    = `PPC_SETTLE,
   parameter        TEMP_BITS = 8
) (
   input  wire       mclk_in,
   input  wire       nrst_in,
   output reg  [1:0] lamp_select_out,
   output reg        host_notify_out,
   output reg        host_notify_oe_out,
   input  wire       ctrl_i2c_clock_pin_in,
   output reg        ctrl_i2c_clock_pin_out,
   output reg        ctrl_i2c_clock_pin_oe_out,
   input  wire       ctrl_i2c_data_pin_in,
   output reg        ctrl_i2c_data_pin_out,
   output reg        ctrl_i2c_data_pin_oe_out,
   output wire       flash_serial_clock_out,
   output wire       flash_tx_out,
   input  wire       flash_rx_in,
   output reg        flash_select0_n_out,
   output reg        aux_select1_n_out,
   input  wire       thermal_compare_in,
   output reg        ramp_charge_out
);

   // ****************************************
   // Boot from flash
   // ****************************************
   localparam [1:0] B_GO   = 2'h0;
   localparam [1:0] B_WAIT = 2'h1;
   localparam [1:0] B_DONE = 2'h2;

   function [7:0] boot_byte;
      input [2:0] idx;
      begin
         boot_byte = (idx == 3'h0) ? `PPC_FLASH_READ : `PPC_FLASH_FILL;
      end
   endfunction

   reg  [1:0] boot_st;
   reg  [2:0] boot_idx;
   reg        spi_go;
   reg  [7:0] spi_tx;
   wire       spi_done;
   wire [7:0] spi_rx;
   wire       booting = (boot_st != B_DONE);
   wire       boot_load = (boot_st == B_WAIT) && spi_done &&
                          (boot_idx == `PPC_BOOT_LAST);

   ppc_spi u_spi (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .go_in    (spi_go),
      .tx_in    (spi_tx),
      .miso_in  (flash_rx_in),
      .done_out (spi_done),
      .rx_out   (spi_rx),
      .sclk_out (flash_serial_clock_out),
      .mosi_out (flash_tx_out)
   );

   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         boot_st             <= B_GO;
         boot_idx            <= 3'h0;
         spi_go              <= 1'b0;
         spi_tx              <= 8'h00;
         flash_select0_n_out <= 1'b1;
         aux_select1_n_out   <= 1'b1;
         host_notify_out     <= 1'b1;
         host_notify_oe_out  <= 1'b0;
      end else begin
         host_notify_oe_out <= 1'b1;
         aux_select1_n_out  <= 1'b1;
         case (boot_st)
            B_GO: begin
               flash_select0_n_out <= 1'b0;
               spi_go  <= 1'b1;
               spi_tx  <= boot_byte(boot_idx);
               boot_st <= B_WAIT;
            end
            B_WAIT: begin
               spi_go <= 1'b0;
               if (spi_done) begin
                  if (boot_idx == `PPC_BOOT_LAST) begin
                     flash_select0_n_out <= 1'b1;
                     host_notify_out     <= 1'b0;
                     boot_st             <= B_DONE;
                  end else begin
                     boot_idx <= boot_idx + 3'h1;
                     boot_st  <= B_GO;
                  end
               end
            end
            B_DONE: begin
               spi_go <= 1'b0;
            end
            default: begin
               boot_st <= B_DONE;
            end
         endcase
      end
   end

   // ****************************************
   // Lamp sequence
   // ****************************************
   reg  [7:0]  ctrl;
   reg  [15:0] slot_cnt;

   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         lamp_select_out <= `PPC_LAMP_NONE;
         slot_cnt        <= 16'h0000;
      end else if (booting || !ctrl[`PPC_CTRL_RUN]) begin
         lamp_select_out <= `PPC_LAMP_NONE;
         slot_cnt        <= 16'h0000;
      end else if (lamp_select_out == `PPC_LAMP_NONE) begin
         lamp_select_out <= `PPC_LAMP_RED;
      end else if (slot_cnt == LAMP_SLOT - 16'h0001) begin
         slot_cnt <= 16'h0000;
         // Blue wraps to red, never through none
         lamp_select_out <= (lamp_select_out == `PPC_LAMP_BLUE) ?
                            `PPC_LAMP_RED : lamp_select_out + 2'h1;
      end else begin
         slot_cnt <= slot_cnt + 16'h0001;
      end
   end

   // ****************************************
   // Temperature SAR
   // ****************************************
   localparam [TEMP_BITS-1:0] MSB = {1'b1, {(TEMP_BITS-1){1'b0}}};
   reg  [TEMP_BITS-1:0] trial;
   reg  [TEMP_BITS-1:0] mask;
   reg  [TEMP_BITS-1:0] pwm_cnt;
   reg  [TEMP_BITS-1:0] result;
   reg  [7:0]           settle_cnt;
   wire [TEMP_BITS-1:0] decided = thermal_compare_in ? trial :
                                  (trial & ~mask);

   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trial           <= MSB;
         mask            <= MSB;
         pwm_cnt         <= {TEMP_BITS{1'b0}};
         result          <= {TEMP_BITS{1'b0}};
         settle_cnt      <= 8'h00;
         ramp_charge_out <= 1'b0;
      end else if (booting) begin
         ramp_charge_out <= 1'b0;
      end else begin
         pwm_cnt         <= pwm_cnt + {{(TEMP_BITS-1){1'b0}}, 1'b1};
         // PWM duty sets the RC level; filter must smooth one period
         ramp_charge_out <= (pwm_cnt < trial);
         if (pwm_cnt == {TEMP_BITS{1'b1}}) begin
            if (settle_cnt == SETTLE - 8'h01) begin
               settle_cnt <= 8'h00;
               if (mask[0]) begin
                  result <= decided;
                  trial  <= MSB;
                  mask   <= MSB;
               end else begin
                  trial <= decided | (mask >> 1);
                  mask  <= mask >> 1;
               end
            end else begin
               settle_cnt <= settle_cnt + 8'h01;
            end
         end
      end
   end

   // ****************************************
   // Control port I2C target
   // ****************************************
   localparam [2:0] I_IDLE = 3'h0;
   localparam [2:0] I_ADDR = 3'h1;
   localparam [2:0] I_AACK = 3'h2;
   localparam [2:0] I_WDAT = 3'h3;
   localparam [2:0] I_WACK = 3'h4;
   localparam [2:0] I_RDAT = 3'h5;
   localparam [2:0] I_RACK = 3'h6;

   reg  [2:0] i_st;
   reg        scl_q;
   reg        sda_q;
   reg  [3:0] bit_cnt;
   reg  [7:0] rx_sh;
   reg  [7:0] tx_sh;
   reg        rd_nack;
   wire scl_rise = ctrl_i2c_clock_pin_in & ~scl_q;
   wire scl_fall = ~ctrl_i2c_clock_pin_in & scl_q;
   wire start = scl_q & ctrl_i2c_clock_pin_in & sda_q & ~ctrl_i2c_data_pin_in;
   wire stop  = scl_q & ctrl_i2c_clock_pin_in & ~sda_q & ctrl_i2c_data_pin_in;
   // Read returns the top byte of the result
   wire [7:0] rd_byte = result[TEMP_BITS-1 -: 8];

   always @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         i_st                      <= I_IDLE;
         scl_q                     <= 1'b1;
         sda_q                     <= 1'b1;
         bit_cnt                   <= 4'h0;
         rx_sh                     <= 8'h00;
         tx_sh                     <= 8'h00;
         rd_nack                   <= 1'b0;
         ctrl                      <= `PPC_CTRL_RESET;
         ctrl_i2c_clock_pin_out    <= 1'b0;
         ctrl_i2c_clock_pin_oe_out <= 1'b0;
         ctrl_i2c_data_pin_out     <= 1'b0;
         ctrl_i2c_data_pin_oe_out  <= 1'b0;
      end else begin
         scl_q <= ctrl_i2c_clock_pin_in;
         sda_q <= ctrl_i2c_data_pin_in;
         if (boot_load) begin
            ctrl <= spi_rx;
         end
         if (scl_rise && i_st != I_IDLE) begin
            rx_sh   <= {rx_sh[6:0], ctrl_i2c_data_pin_in};
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (start) begin
            i_st    <= I_ADDR;
            bit_cnt <= 4'h0;
            ctrl_i2c_data_pin_oe_out <= 1'b0;
         end else if (stop) begin
            i_st <= I_IDLE;
            ctrl_i2c_data_pin_oe_out <= 1'b0;
         end else if (scl_fall) begin
            case (i_st)
               I_ADDR: if (bit_cnt == `PPC_I2C_BITS) begin
                  bit_cnt <= 4'h0;
                  if (rx_sh[7:1] == I2C_ADDR) begin
                     i_st <= I_AACK;
                     ctrl_i2c_data_pin_oe_out <= 1'b1;
                  end else begin
                     i_st <= I_IDLE;
                  end
               end
               I_AACK, I_RACK: begin
                  bit_cnt <= 4'h0;
                  // Ack bit already shifted in, so R/W sits at bit 1
                  if (i_st == I_AACK ? rx_sh[1] : !rd_nack) begin
                     i_st  <= I_RDAT;
                     tx_sh <= {rd_byte[6:0], 1'b0};
                     ctrl_i2c_data_pin_oe_out <= ~rd_byte[7];
                  end else begin
                     i_st <= (i_st == I_AACK) ? I_WDAT : I_IDLE;
                     ctrl_i2c_data_pin_oe_out <= 1'b0;
                  end
               end
               I_WDAT: if (bit_cnt == `PPC_I2C_BITS) begin
                  bit_cnt <= 4'h0;
                  ctrl    <= rx_sh;
                  i_st    <= I_WACK;
                  ctrl_i2c_data_pin_oe_out <= 1'b1;
               end
               I_WACK: begin
                  bit_cnt <= 4'h0;
                  i_st    <= I_WDAT;
                  ctrl_i2c_data_pin_oe_out <= 1'b0;
               end
               I_RDAT: if (bit_cnt == `PPC_I2C_BITS) begin
                  i_st <= I_RACK;
                  ctrl_i2c_data_pin_oe_out <= 1'b0;
               end else begin
                  tx_sh <= {tx_sh[6:0], 1'b0};
                  ctrl_i2c_data_pin_oe_out <= ~tx_sh[7];
               end
               default: begin
                  ctrl_i2c_data_pin_oe_out <= 1'b0;
               end
            endcase
         end
         if (scl_rise && i_st == I_RACK) begin
            rd_nack <= ctrl_i2c_data_pin_in;
         end
      end
   end

endmodule

`default_nettype wire
